// >>> verilog/acct_core.sv
// Purpose: alert limit compare, conversion sequencing and timing, apb registers
// Assumes: pclk 40 MHz, sampled analog values arrive as synchronous inputs
// Notes: conversion results are mocked by sampling the value inputs
`timescale 1ns/1ps
`default_nettype none
`include "acct_defines.svh"

// Behaviour
// - shunt over-limit checked after each shunt conversion
// - flag at mask bit 4 marks limit violation
// - alert pin level follows polarity bit 1
// - latch holds until config write or mask read
// - bus limits checked after each bus conversion
// - power limit checked after each bus conversion
// - conversion durations span 140 us to 8.244 ms
// - separate shunt, bus durations and averaging count
// - highest enabled alert function bit wins
// - mode 111 converts shunt then bus repeatedly
module acct_core #(
  parameter int CT_MAX_CYC = `ACCT_CT_MAX_NS / `ACCT_CLK_NS
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measured values from the converter front end
  input wire logic [15:0] shunt_value,
  input wire logic [15:0] bus_value,
  input wire logic [15:0] power_value,
  // alert pin, open drain
  input wire logic alert_in,
  output logic alert_out,
  output logic alert_oe,
  // interrupt
  output logic irq
);

  // ****************************************************************
  // conversion duration table
  // ****************************************************************
  localparam int CT_MIN_CYC = (`ACCT_CT_MIN_NS + `ACCT_CLK_NS - 1) / `ACCT_CLK_NS;

  // eight duration codes in ns, ends are the shortest and longest settings
  function automatic logic [18:0] ct_cycles(input logic [2:0] code);
    int ns;
    ns = `ACCT_CT_MIN_NS;
    case (code)
      3'h0: ns = `ACCT_CT_MIN_NS;
      3'h1: ns = 204000;
      3'h2: ns = 332000;
      3'h3: ns = 588000;
      3'h4: ns = 1100000;
      3'h5: ns = 2116000;
      3'h6: ns = 4156000;
      default: ns = `ACCT_CT_MAX_NS;
    endcase
    if (code == 3'h7) begin
      ct_cycles = 19'(CT_MAX_CYC); // parameter lets a bench shorten the longest
    end else if (code == 3'h0) begin
      ct_cycles = 19'(CT_MIN_CYC);
    end else begin
      ct_cycles = 19'(ns / `ACCT_CLK_NS);
    end
  endfunction

  // averaging code to sample count
  function automatic logic [9:0] avg_count(input logic [2:0] code);
    case (code)
      3'h0: avg_count = 10'h001;
      3'h1: avg_count = 10'h004;
      3'h2: avg_count = 10'h010;
      3'h3: avg_count = 10'h040;
      3'h4: avg_count = 10'h080;
      3'h5: avg_count = 10'h100;
      3'h6: avg_count = 10'h200;
      default: avg_count = 10'h3ff;
    endcase
  endfunction

  // one-hot alert functions, highest set bit selected
  function automatic logic [4:0] pick_func(input logic [15:0] m);
    pick_func = 5'h00;
    if (m[`ACCT_MASK_SHUNT_OVER_LIMIT]) begin
      pick_func = 5'h10;
    end else if (m[`ACCT_MASK_SHUNT_UNDER_LIMIT]) begin
      pick_func = 5'h08;
    end else if (m[`ACCT_MASK_BUS_OVER_LIMIT]) begin
      pick_func = 5'h04;
    end else if (m[`ACCT_MASK_BUS_UNDER_LIMIT]) begin
      pick_func = 5'h02;
    end else if (m[`ACCT_MASK_POWER_OVER_LIMIT]) begin
      pick_func = 5'h01;
    end
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  acct_pkg::acct_state_s st_ff;
  acct_pkg::acct_state_s nxt_st;

  logic wr_en;
  logic rd_en;
  logic [4:0] func;
  logic [2:0] mode;
  logic [2:0] ct_shunt;
  logic [2:0] ct_bus;
  logic shunt_done;
  logic bus_done;
  logic violate;

  // apb access phase, zero wait states
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign func = pick_func(st_ff.mask);
  assign mode = st_ff.cfg[`ACCT_CFG_MODE_LO +: 3];
  assign ct_shunt = st_ff.cfg[`ACCT_CFG_VSH_LO +: 3];
  assign ct_bus = st_ff.cfg[`ACCT_CFG_VBUS_LO +: 3];
  assign shunt_done = (st_ff.phase == acct_pkg::ACCT_SHUNT) && (st_ff.tmr == 19'h0_0000);
  assign bus_done = (st_ff.phase == acct_pkg::ACCT_BUS) && (st_ff.tmr == 19'h0_0000);

  // limit compare, signed for shunt, unsigned for bus and power
  always_comb begin
    violate = 1'b0;
    if (shunt_done) begin
      violate = (func[4] && ($signed(shunt_value) > $signed(st_ff.limit))) ||
                (func[3] && ($signed(shunt_value) < $signed(st_ff.limit)));
    end
    if (bus_done) begin
      violate = (func[2] && (bus_value > st_ff.limit)) ||
                (func[1] && (bus_value < st_ff.limit)) ||
                (func[0] && (power_value > st_ff.limit));
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.prdata = 32'h0000_0000;
    // conversion sequencer
    case (st_ff.phase)
      acct_pkg::ACCT_IDLE: begin
        if (mode == `ACCT_MODE_CONT) begin
          nxt_st.phase = acct_pkg::ACCT_SHUNT;
          nxt_st.tmr = ct_cycles(ct_shunt) - 19'h0_0001;
        end
      end
      acct_pkg::ACCT_SHUNT: begin
        if (st_ff.tmr != 19'h0_0000) begin
          nxt_st.tmr = st_ff.tmr - 19'h0_0001;
        end else begin
          nxt_st.shunt_in = shunt_value;
          nxt_st.phase = acct_pkg::ACCT_BUS;
          nxt_st.tmr = ct_cycles(ct_bus) - 19'h0_0001;
        end
      end
      acct_pkg::ACCT_BUS: begin
        if (st_ff.tmr != 19'h0_0000) begin
          nxt_st.tmr = st_ff.tmr - 19'h0_0001;
        end else begin
          nxt_st.bus_in = bus_value;
          nxt_st.power_in = power_value;
          if (st_ff.avg_cnt + 10'h001 >= avg_count(st_ff.cfg[`ACCT_CFG_AVG_LO +: 3])) begin
            nxt_st.avg_cnt = 10'h000;
            nxt_st.shunt_res = st_ff.shunt_in;
            nxt_st.bus_res = bus_value;
            nxt_st.power_res = power_value;
            nxt_st.cvrf = 1'b1;
            nxt_st.irq_stat[1] = 1'b1;
          end else begin
            nxt_st.avg_cnt = st_ff.avg_cnt + 10'h001;
          end
          if (mode == `ACCT_MODE_CONT) begin
            nxt_st.phase = acct_pkg::ACCT_SHUNT;
            nxt_st.tmr = ct_cycles(ct_shunt) - 19'h0_0001;
          end else begin
            nxt_st.phase = acct_pkg::ACCT_IDLE;
          end
        end
      end
      default: nxt_st.phase = acct_pkg::ACCT_IDLE;
    endcase

    // latched flag: clear by config write or mask read, set wins
    if (st_ff.mask[`ACCT_MASK_LEN]) begin
      if ((wr_en && paddr == `ACCT_OFF_CFG) || (rd_en && paddr == `ACCT_OFF_MASK)) begin
        nxt_st.alert_flag = 1'b0;
      end
    end else if (shunt_done || bus_done) begin
      nxt_st.alert_flag = 1'b0; // transparent: follows each compare
    end
    if (rd_en && paddr == `ACCT_OFF_MASK) begin
      nxt_st.cvrf = 1'b0;
    end
    if (wr_en && paddr == `ACCT_OFF_CFG) begin
      nxt_st.cvrf = 1'b0;
    end
    if (violate) begin
      nxt_st.alert_flag = 1'b1;
      nxt_st.irq_stat[0] = 1'b1;
    end

    // register writes
    if (wr_en) begin
      case (paddr)
        `ACCT_OFF_CFG: begin
          nxt_st.cfg = pwdata[15:0];
          nxt_st.avg_cnt = 10'h000;
          nxt_st.phase = acct_pkg::ACCT_IDLE; // restart with new timing
        end
        `ACCT_OFF_MASK: nxt_st.mask = pwdata[15:0] & `ACCT_MASK_WMASK;
        `ACCT_OFF_LIMIT: nxt_st.limit = pwdata[15:0];
        `ACCT_OFF_IRQ_EN: nxt_st.irq_en = pwdata[1:0];
        `ACCT_OFF_IRQ_CLR: nxt_st.irq_stat = st_ff.irq_stat & ~pwdata[1:0] |
                                             {nxt_st.irq_stat[1] & ~st_ff.irq_stat[1],
                                              violate};
        default: ;
      endcase
    end

    // register reads, captured for the access phase edge
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `ACCT_OFF_CFG: nxt_st.prdata = {16'h0000, st_ff.cfg};
        `ACCT_OFF_MASK: nxt_st.prdata = {16'h0000, st_ff.mask[15:5], st_ff.alert_flag,
                                         st_ff.cvrf, st_ff.mask[2:0]};
        `ACCT_OFF_LIMIT: nxt_st.prdata = {16'h0000, st_ff.limit};
        `ACCT_OFF_SHUNT_RES: nxt_st.prdata = {16'h0000, st_ff.shunt_res};
        `ACCT_OFF_BUS_RES: nxt_st.prdata = {16'h0000, st_ff.bus_res};
        `ACCT_OFF_POWER_RES: nxt_st.prdata = {16'h0000, st_ff.power_res};
        `ACCT_OFF_IRQ_STAT: nxt_st.prdata = {30'h0000_0000, st_ff.irq_stat};
        `ACCT_OFF_IRQ_EN: nxt_st.prdata = {30'h0000_0000, st_ff.irq_en};
        default: nxt_st.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // async reset to constants only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.phase <= acct_pkg::ACCT_IDLE;
      st_ff.cfg <= `ACCT_CFG_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // unmapped addresses answer with an error; reads of write-only clear give zero
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      `ACCT_OFF_CFG, `ACCT_OFF_MASK, `ACCT_OFF_LIMIT, `ACCT_OFF_SHUNT_RES,
      `ACCT_OFF_BUS_RES, `ACCT_OFF_POWER_RES, `ACCT_OFF_IRQ_STAT,
      `ACCT_OFF_IRQ_EN, `ACCT_OFF_IRQ_CLR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign prdata = st_ff.prdata;
  // open drain: polarity picks whether the active level is driven low
  // active-high mode drives low while idle so the pull-up never asserts it
  assign alert_out = 1'b0;
  assign alert_oe = st_ff.mask[`ACCT_MASK_ALERT_POLARITY_SELECT] ? ~st_ff.alert_flag :
                    st_ff.alert_flag;
  assign irq = |(st_ff.irq_stat & st_ff.irq_en);

endmodule
`default_nettype wire

// >>> pkg/acct_defines.svh
// Purpose: constants for the alert compare and conversion timing block
// Assumes: 40 MHz pclk, APB byte addressing
// Notes: offsets are byte addresses, all registers one aligned word
`ifndef ACCT_DEFINES_SVH
`define ACCT_DEFINES_SVH

// ****************************************************************
// register map
// ****************************************************************
`define ACCT_OFF_CFG      8'h00
`define ACCT_OFF_MASK     8'h18
`define ACCT_OFF_LIMIT    8'h1c
`define ACCT_OFF_SHUNT    8'h20
`define ACCT_OFF_BUS      8'h24
`define ACCT_OFF_POWER    8'h28
`define ACCT_OFF_SHUNT_RES 8'h2c
`define ACCT_OFF_BUS_RES  8'h30
`define ACCT_OFF_POWER_RES 8'h34
`define ACCT_OFF_IRQ_STAT 8'h38
`define ACCT_OFF_IRQ_EN   8'h3c
`define ACCT_OFF_IRQ_CLR  8'h40

// ****************************************************************
// field positions
// ****************************************************************
`define ACCT_CFG_RESET    16'h4127
`define ACCT_CFG_MODE_LO  0
`define ACCT_CFG_VSH_LO   3
`define ACCT_CFG_VBUS_LO  6
`define ACCT_CFG_AVG_LO   9
`define ACCT_MODE_CONT    3'h7
`define ACCT_MASK_LEN     0
`define ACCT_MASK_ALERT_POLARITY_SELECT 1
`define ACCT_MASK_CVRF    3
`define ACCT_MASK_ALERT_FUNCTION_FLAG 4
`define ACCT_MASK_CNVR    10
`define ACCT_MASK_POWER_OVER_LIMIT 11
`define ACCT_MASK_BUS_UNDER_LIMIT 12
`define ACCT_MASK_BUS_OVER_LIMIT 13
`define ACCT_MASK_SHUNT_UNDER_LIMIT 14
`define ACCT_MASK_SHUNT_OVER_LIMIT 15
`define ACCT_MASK_WMASK   16'hfc03

// ****************************************************************
// timing: conversion durations in ns, shortest and longest
// ****************************************************************
`define ACCT_CLK_NS       25
`define ACCT_CT_MIN_NS    140000
`define ACCT_CT_MAX_NS    8244000
`endif

// >>> pkg/acct_pkg.sv
// Purpose: types for the alert compare and conversion timing block
// Assumes: used with acct_defines.svh
// Notes: nothing imported, use acct_pkg::name
package acct_pkg;
  // conversion sequencer phases
  typedef enum logic [2:0] {
    ACCT_IDLE  = 3'b001,
    ACCT_SHUNT = 3'b010,
    ACCT_BUS   = 3'b100
  } acct_phase_e;

  typedef struct packed {
    acct_phase_e phase;
    logic [15:0] cfg;
    logic [15:0] mask;
    logic [15:0] limit;
    logic [15:0] shunt_in;
    logic [15:0] bus_in;
    logic [15:0] power_in;
    logic [15:0] shunt_res;
    logic [15:0] bus_res;
    logic [15:0] power_res;
    logic [18:0] tmr;
    logic [9:0] avg_cnt;
    logic alert_flag;
    logic cvrf;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [31:0] prdata;
  } acct_state_s;
endpackage

// >>> dv/acct_front_model.sv
// Purpose: front end levels and alert pin model
// Assumes: levels requested by the bench
// Notes: pin has a pull-up, so released means high
`timescale 1ns/1ps
`default_nettype none
module acct_front_model (
  // requested levels
  input wire logic [15:0] shunt_req,
  input wire logic [15:0] bus_req,
  input wire logic [15:0] power_req,
  // toward the block
  output logic [15:0] shunt_value,
  output logic [15:0] bus_value,
  output logic [15:0] power_value,
  // alert pin
  input wire logic alert_out,
  input wire logic alert_oe,
  output logic alert_in
);
  // analog levels pass straight through
  assign shunt_value = shunt_req;
  assign bus_value = bus_req;
  assign power_value = power_req;
  // released pin floats up, never keeps the last driven level
  assign alert_in = alert_oe ? alert_out : 1'b1;
endmodule
`default_nettype wire

// >>> dv/acct_core_chk.sv
// Purpose: port level checks for acct_core
// Assumes: mask and irq enable shadowed from taken apb writes
// Notes: alert flag rebuilt from pin enable and polarity
`timescale 1ns/1ps
`default_nettype none
`include "acct_defines.svh"
module acct_core_chk (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // alert and interrupt
  input wire logic alert_out,
  input wire logic alert_oe,
  input wire logic irq
);
  // ****************************************
  // shadows
  // ****************************************
  logic acc;
  logic flag;
  logic [15:0] mask_ff;
  logic [1:0] en_ff;
  assign acc = psel && penable && pready;
  assign flag = alert_oe ^ mask_ff[1];
  // only taken writes count, same edge as the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= 16'h0000;
      en_ff <= 2'b00;
    end else if (acc && pwrite) begin
      if (paddr == `ACCT_OFF_MASK) mask_ff <= pwdata[15:0];
      if (paddr == `ACCT_OFF_IRQ_EN) en_ff <= pwdata[1:0];
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_always: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (acc && paddr inside {8'h20, 8'h24, 8'h28}
    |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped access");
  a_mapped_ok: assert property (acc && paddr == `ACCT_OFF_CFG |-> !pslverr)
    else $error("config refused");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_pin_pulls_low: assert property (alert_oe |-> !alert_out)
    else $error("pin driven high");
  a_latch_hold: assert property (mask_ff[0] && flag && $stable(mask_ff) &&
    !(acc && paddr inside {`ACCT_OFF_CFG, `ACCT_OFF_MASK}) |=> flag)
    else $error("latched alert dropped");
  a_restart_quiet: assert property ((acc && pwrite && paddr == `ACCT_OFF_CFG)
    ##1 !flag |=> !flag [*4]) else $error("alert right after restart");
  a_rise_needs_fn: assert property ($rose(flag) &&
    mask_ff[1] == $past(mask_ff[1], 2) |-> $past(mask_ff[15:11]) != 5'b00000)
    else $error("alert with no function");
  a_irq_masked: assert property (en_ff == 2'b00 && $past(en_ff) == 2'b00 |-> !irq)
    else $error("irq while disabled");
  a_irq_cause: assert property ($rose(irq) |-> (en_ff | $past(en_ff)) != 2'b00)
    else $error("irq rose while disabled");
  c_alert: cover property ($rose(flag));
  c_irq: cover property ($rose(irq));
  c_err: cover property (acc && pslverr);
endmodule
bind acct_core acct_core_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .alert_out(alert_out), .alert_oe(alert_oe), .irq(irq));
`default_nettype wire

// >>> dv/acct_core_tb.sv
// Purpose: self-checking bench for acct_core
// Assumes: CT_MAX_CYC 20, code 7 conversions only
// Notes: random limits and levels, latched alert seen at pin and mask
`timescale 1ns/1ps
`default_nettype none
`include "acct_defines.svh"
module acct_core_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic alert_in, alert_out, alert_oe, irq, err_bit, alert_polarity_select, exp_f;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [15:0] shunt_req, bus_req, power_req, shunt_value, bus_value, power_value, lim;
  logic [4:0] fn;
  int err_total = 0;
  int comparisons = 0;
  int seed = 62207;
  int cyc = 0;
  // short code 7 keeps each conversion at 20 cycles
  acct_core #(.CT_MAX_CYC(20)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .shunt_value(shunt_value), .bus_value(bus_value),
    .power_value(power_value), .alert_in(alert_in), .alert_out(alert_out),
    .alert_oe(alert_oe), .irq(irq));
  acct_front_model u_front (.shunt_req(shunt_req), .bus_req(bus_req),
    .power_req(power_req), .shunt_value(shunt_value), .bus_value(bus_value),
    .power_value(power_value), .alert_out(alert_out), .alert_oe(alert_oe),
    .alert_in(alert_in));
  // ****************************************
  // helpers
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard, run needs about 2600 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      wrap_up;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; an idle edge first so psel never toggles twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_data = prdata;
    err_bit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) err_total++;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // highest enabled function decides; shunt is signed
  function automatic logic exp_flag(input logic [4:0] f, input logic [15:0] l, s, b, p);
    if (f[4]) return $signed(s) > $signed(l);
    if (f[3]) return $signed(s) < $signed(l);
    if (f[2]) return b > l;
    if (f[1]) return b < l;
    return f[0] && p > l;
  endfunction
  // never equal to the limit, so over and under are clear cut
  function automatic logic [15:0] pick(input logic [15:0] l);
    logic [15:0] d;
    d = 16'h0001 + 16'($random(seed) & 32'h0000_00ff);
    return (($random(seed) & 1) != 0) ? l + d : l - d;
  endfunction
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    shunt_req = 16'h0000;
    bus_req = 16'h0000;
    power_req = 16'h0000;
    idle(3);
    presetn <= 1'b1;
    apb(1'b0, `ACCT_OFF_CFG, 32'h0000_0000);
    chk(rd_data, 32'h0000_4127);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({rd_data[30:0], err_bit}, 32'h0000_0001);
    apb(1'b1, `ACCT_OFF_CFG, 32'h0000_01ff);
    apb(1'b0, `ACCT_OFF_CFG, 32'h0000_0000);
    chk(rd_data, 32'h0000_01ff);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      fn = (i < 5) ? 5'b00001 << i : 5'($random(seed));
      alert_polarity_select = 1'($random(seed));
      lim = 16'h2000 + 16'($random(seed) & 32'h0000_1fff);
      shunt_req <= pick(lim);
      bus_req <= pick(lim);
      power_req <= pick(lim);
      // no function armed while limit and restart change, so no stale latch
      apb(1'b1, `ACCT_OFF_MASK, {16'h0000, 5'h00, 9'h000, alert_polarity_select, 1'b1});
      apb(1'b1, `ACCT_OFF_LIMIT, {16'h0000, lim});
      apb(1'b1, `ACCT_OFF_CFG, 32'h0000_01ff);
      apb(1'b1, `ACCT_OFF_MASK, {16'h0000, fn, 9'h000, alert_polarity_select, 1'b1});
      idle(120);
      exp_f = exp_flag(fn, lim, shunt_req, bus_req, power_req);
      chk({31'h0, alert_oe}, {31'h0, exp_f ^ alert_polarity_select});
      shunt_req <= lim;
      bus_req <= lim;
      power_req <= lim;
      idle(60);
      chk({31'h0, alert_oe}, {31'h0, exp_f ^ alert_polarity_select});
      apb(1'b0, `ACCT_OFF_SHUNT_RES, 32'h0000_0000);
      chk(rd_data, {16'h0000, lim});
      apb(1'b0, `ACCT_OFF_MASK, 32'h0000_0000);
      chk({31'h0, rd_data[4]}, {31'h0, exp_f});
      idle(3);
      chk({31'h0, alert_oe}, {31'h0, alert_polarity_select});
      $display("test alert %0d done", i);
    end
    apb(1'b1, `ACCT_OFF_IRQ_CLR, 32'h0000_0003);
    apb(1'b1, `ACCT_OFF_IRQ_EN, 32'h0000_0002);
    for (int k = 0; k < 200 && irq !== 1'b1; k++) @(posedge pclk);
    chk({31'h0, irq}, 32'h0000_0001);
    apb(1'b0, `ACCT_OFF_IRQ_STAT, 32'h0000_0000);
    chk(rd_data & 32'h0000_0002, 32'h0000_0002);
    apb(1'b1, `ACCT_OFF_IRQ_EN, 32'h0000_0000);
    idle(2);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `ACCT_OFF_IRQ_CLR, 32'h0000_0003);
    apb(1'b1, `ACCT_OFF_IRQ_EN, 32'h0000_0001);
    idle(60);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `ACCT_OFF_MASK, 32'h0000_8001);
    shunt_req <= lim + 16'h0040;
    idle(60);
    chk({31'h0, irq}, 32'h0000_0001);
    $display("test irq done");
    wrap_up;
  end
endmodule
`default_nettype wire
